// ---- logic/dsp_exec.sv ----
// Execute unit for multiply, stack, return, rotate, status and repeat instructions.
// Behaviour
// - Multiply loads product with multiplicand times memory, 13-bit or 16-bit immediate.
// - Multiply-accumulate adds scaled old product to accumulator, forms new product.
// - Short-immediate multiply treats its 13-bit constant as signed.
// - Multiply-subtract subtracts scaled old product from accumulator, forms new product.
// - Unsigned multiply treats both operands as unsigned.
// - Negate replaces accumulator with its two's complement.
// - Software interrupt jumps to vector 24h exactly like hardware interrupt.
// - Normalize shifts the signed accumulator left one bit when nonzero and not yet normalized.
// - OR combines accumulator with memory or shifted immediate, zeros elsewhere.
// - Port output writes memory word to port with I/O select low.
// - Product load copies scaled product into accumulator.
// - Pop to accumulator fills low half, clears high half, pops.
// - Pop to memory stores top entry then pops.
// - Push from memory pushes down then stores memory word on top.
// - Push accumulator pushes down then stores low accumulator half on top.
// - Carry clear sets carry to zero.
// - Return loads program counter from top entry and pops.
// - Conditional return returns only when all chosen conditions hold.
// - Rotates move accumulator exactly one bit left or right.
// - Saturation clear turns off result saturation.
// - Repeat loads count from memory low byte or immediate; runs next count+1 times.
// - Short repeat loads 8-bit immediate count; runs next count+1 times.
// - Product shift: none, left one, left four, right six sign-extended.
module dsp_exec (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  // Instruction issue
  input  wire logic            instr_valid_i,
  input  wire ex_pkg::op_t     instr_op_i,
  input  wire ex_pkg::src_t    instr_src_i,
  input  wire logic [15:0]     instr_imm_i,
  input  wire logic [3:0]      instr_shift_i,
  input  wire logic [5:0]      instr_cond_i,
  input  wire logic [15:0]     next_pc_i,
  output logic                 instr_ready_o,
  // Data memory
  input  wire logic [15:0]     mem_data_i,
  output logic                 mem_wr_o,
  output logic [15:0]          mem_wdata_o,
  // Program counter
  output logic                 pc_load_o,
  output logic [15:0]          pc_value_o,
  // I/O port space
  input  wire logic            ready_i,
  output logic                 io_space_select_n_o,
  output logic                 external_access_strobe_n_o,
  output logic                 io_read_write_o,
  output logic [15:0]          io_addr_o,
  output logic [15:0]          io_data_o,
  // Register port
  input  wire logic [2:0]      reg_addr_i,
  input  wire logic [31:0]     reg_wdata_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  output logic [31:0]          reg_rdata_o
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {S_IDLE, S_REP, S_IO} fsm_t;
  typedef logic [ex_pkg::STACK_DEPTH-1:0][15:0] stack_t;

  typedef struct packed {
    fsm_t          fsm;
    logic [31:0]   acc;
    logic [31:0]   prod;
    logic [15:0]   mcand;
    logic          carry;
    logic          sat_mode;
    logic [1:0]    pshift;
    logic [15:0]   rcount;
    logic          armed;
    stack_t        stk;
    ex_pkg::op_t   h_op;
    ex_pkg::src_t  h_src;
    logic [15:0]   h_imm;
    logic [3:0]    h_shift;
    logic [5:0]    h_cond;
    logic          io_n;
    logic          strobe_n;
    logic          rw;
    logic [15:0]   io_addr;
    logic [15:0]   io_data;
    logic          pc_load;
    logic [15:0]   pc_value;
    logic          mem_wr;
    logic [15:0]   mem_wdata;
    logic [31:0]   rdata;
  } state_t;

  state_t        s_reg;
  state_t        s_next;
  logic          go;
  logic          in_rep;
  ex_pkg::op_t   e_op;
  ex_pkg::src_t  e_src;
  logic [15:0]   e_imm;
  logic [3:0]    e_shift;
  logic [5:0]    e_cond;
  logic [15:0]   opnd;
  logic [15:0]   short_opnd;
  logic [15:0]   rep_src;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [31:0] pscale(input logic [31:0] p, input logic [1:0] m);
    case (m)
      ex_pkg::PSHIFT_LEFT1:  pscale = p << 1;
      ex_pkg::PSHIFT_LEFT4:  pscale = p << ex_pkg::PSHIFT_L4_AMT;
      ex_pkg::PSHIFT_RIGHT6: pscale = $signed(p) >>> ex_pkg::PSHIFT_R6_AMT;
      default:               pscale = p;
    endcase
  endfunction

  // Adds or subtracts with one guard bit and saturates when enabled.
  function automatic logic [31:0] accum(input logic [31:0] a, input logic [31:0] b,
                                        input logic sub, input logic sat);
    logic [32:0] r;
    r = sub ? {a[31], a} - {b[31], b} : {a[31], a} + {b[31], b};
    if (sat && (r[32] != r[31])) accum = r[32] ? ex_pkg::SAT_MIN : ex_pkg::SAT_MAX;
    else accum = r[31:0];
  endfunction

  function automatic logic [31:0] smul(input logic [15:0] a, input logic [15:0] b);
    smul = 32'($signed(a)) * 32'($signed(b));
  endfunction

  function automatic stack_t push(input stack_t st, input logic [15:0] v);
    for (int i = ex_pkg::STACK_DEPTH - 1; i > 0; i--) st[i] = st[i-1];
    st[0] = v;
    return st;
  endfunction

  // The bottom entry is duplicated on a pop, as in a shift-register stack.
  function automatic stack_t pop(input stack_t st);
    for (int i = 0; i < ex_pkg::STACK_DEPTH - 1; i++) st[i] = st[i+1];
    return st;
  endfunction

  function automatic logic cond_met(input logic [5:0] c, input logic [31:0] a, input logic cy);
    logic [5:0] h;
    h                 = '0;
    h[ex_pkg::COND_EQ] = (a == '0);
    h[ex_pkg::COND_NE] = (a != '0);
    h[ex_pkg::COND_LT] = a[31];
    h[ex_pkg::COND_GT] = !a[31] && (a != '0);
    h[ex_pkg::COND_C]  = cy;
    h[ex_pkg::COND_NC] = !cy;
    cond_met = &(~c | h);
  endfunction

  // Flow-changing and I/O instructions run once even after a repeat.
  function automatic logic one_shot(input ex_pkg::op_t op);
    one_shot = (op == ex_pkg::port_out_op) || (op == ex_pkg::subroutine_return_op) ||
               (op == ex_pkg::conditional_return_op) || (op == ex_pkg::soft_nmi_op) ||
               (op == ex_pkg::repeat_next_op) || (op == ex_pkg::repeat_short_immediate_op);
  endfunction

  // ****************************************
  // Operand selection
  // ****************************************
  assign in_rep     = (s_reg.fsm == S_REP);
  assign go         = in_rep || ((s_reg.fsm == S_IDLE) && instr_valid_i);
  assign e_op       = in_rep ? s_reg.h_op : instr_op_i;
  assign e_src      = in_rep ? s_reg.h_src : instr_src_i;
  assign e_imm      = in_rep ? s_reg.h_imm : instr_imm_i;
  assign e_shift    = in_rep ? s_reg.h_shift : instr_shift_i;
  assign e_cond     = in_rep ? s_reg.h_cond : instr_cond_i;
  assign short_opnd = 16'($signed(e_imm[ex_pkg::SHORT_IMM_W-1:0]));

  always_comb begin
    case (e_src)
      ex_pkg::SRC_SHORT: opnd = short_opnd;
      ex_pkg::SRC_LONG:  opnd = e_imm;
      default:           opnd = mem_data_i;
    endcase
    case (e_src)
      ex_pkg::SRC_MEM: rep_src = 16'(mem_data_i[ex_pkg::REPEAT_SHORT_W-1:0]);
      ex_pkg::SRC_LONG: rep_src = e_imm;
      default:          rep_src = 16'(e_imm[ex_pkg::REPEAT_SHORT_W-1:0]);
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next         = s_reg;
    s_next.pc_load = 1'b0;
    s_next.mem_wr  = 1'b0;
    s_next.rdata   = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ex_pkg::REG_STATUS: begin
          s_next.rdata[ex_pkg::ST_PSHIFT +: 2] = s_reg.pshift;
          s_next.rdata[ex_pkg::ST_CARRY]       = s_reg.carry;
          s_next.rdata[ex_pkg::ST_SAT]         = s_reg.sat_mode;
        end
        ex_pkg::REG_ACC:   s_next.rdata = s_reg.acc;
        ex_pkg::REG_PROD:  s_next.rdata = s_reg.prod;
        ex_pkg::REG_MCAND: s_next.rdata = {16'h0000, s_reg.mcand};
        ex_pkg::REG_COUNT: s_next.rdata = {16'h0000, s_reg.rcount};
        ex_pkg::REG_TOP:   s_next.rdata = {16'h0000, s_reg.stk[0]};
        default:           s_next.rdata = '0;
      endcase
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        ex_pkg::REG_STATUS: begin
          s_next.pshift   = reg_wdata_i[ex_pkg::ST_PSHIFT +: 2];
          s_next.carry    = reg_wdata_i[ex_pkg::ST_CARRY];
          s_next.sat_mode = reg_wdata_i[ex_pkg::ST_SAT];
        end
        ex_pkg::REG_MCAND: s_next.mcand = reg_wdata_i[15:0];
        default: ;
      endcase
    end
    if (go) begin
      case (e_op)
        ex_pkg::multiply_op: s_next.prod = smul(s_reg.mcand, opnd);
        ex_pkg::multiply_accumulate_op: begin
          s_next.acc  = accum(s_reg.acc, pscale(s_reg.prod, s_reg.pshift), 1'b0, s_reg.sat_mode);
          s_next.prod = smul(s_reg.mcand, mem_data_i);
        end
        ex_pkg::multiply_short_immediate_op: s_next.prod = smul(s_reg.mcand, short_opnd);
        ex_pkg::multiply_subtract_op: begin
          s_next.acc  = accum(s_reg.acc, pscale(s_reg.prod, s_reg.pshift), 1'b1, s_reg.sat_mode);
          s_next.prod = smul(s_reg.mcand, mem_data_i);
        end
        ex_pkg::multiply_unsigned_op: s_next.prod = 32'(s_reg.mcand) * 32'(mem_data_i);
        ex_pkg::negate_op: s_next.acc = accum('0, s_reg.acc, 1'b1, s_reg.sat_mode);
        ex_pkg::soft_nmi_op: begin
          s_next.stk      = push(s_reg.stk, next_pc_i);
          s_next.pc_load  = 1'b1;
          s_next.pc_value = ex_pkg::NMI_VECTOR;
        end
        ex_pkg::normalize_op: begin
          if ((s_reg.acc != '0) && (s_reg.acc[31] == s_reg.acc[30])) s_next.acc = s_reg.acc << 1;
        end
        ex_pkg::or_op: begin
          if (e_src == ex_pkg::SRC_MEM) s_next.acc = s_reg.acc | {16'h0000, mem_data_i};
          else s_next.acc = s_reg.acc | ({16'h0000, e_imm} << e_shift);
        end
        ex_pkg::port_out_op: begin
          s_next.fsm      = S_IO;
          s_next.io_n     = 1'b0;
          s_next.strobe_n = 1'b0;
          s_next.rw       = 1'b0;
          s_next.io_addr  = e_imm;
          s_next.io_data  = mem_data_i;
        end
        ex_pkg::product_to_accumulator_op: s_next.acc = pscale(s_reg.prod, s_reg.pshift);
        ex_pkg::pop_to_accumulator_op: begin
          s_next.acc = {16'h0000, s_reg.stk[0]};
          s_next.stk = pop(s_reg.stk);
        end
        ex_pkg::pop_to_memory_op: begin
          s_next.mem_wr    = 1'b1;
          s_next.mem_wdata = s_reg.stk[0];
          s_next.stk       = pop(s_reg.stk);
        end
        ex_pkg::push_from_memory_op: s_next.stk = push(s_reg.stk, mem_data_i);
        ex_pkg::push_accumulator_op: s_next.stk = push(s_reg.stk, s_reg.acc[15:0]);
        ex_pkg::carry_clear_op: s_next.carry = 1'b0;
        ex_pkg::subroutine_return_op: begin
          s_next.pc_load  = 1'b1;
          s_next.pc_value = s_reg.stk[0];
          s_next.stk      = pop(s_reg.stk);
        end
        ex_pkg::conditional_return_op: begin
          if (cond_met(e_cond, s_reg.acc, s_reg.carry)) begin
            s_next.pc_load  = 1'b1;
            s_next.pc_value = s_reg.stk[0];
            s_next.stk      = pop(s_reg.stk);
          end
        end
        ex_pkg::rotate_left_op: begin
          s_next.carry = s_reg.acc[31];
          s_next.acc   = {s_reg.acc[30:0], s_reg.carry};
        end
        ex_pkg::rotate_right_op: begin
          s_next.carry = s_reg.acc[0];
          s_next.acc   = {s_reg.carry, s_reg.acc[31:1]};
        end
        ex_pkg::saturation_mode_clear_op: s_next.sat_mode = 1'b0;
        ex_pkg::repeat_next_op: begin
          s_next.rcount = rep_src;
          s_next.armed  = 1'b1;
        end
        ex_pkg::repeat_short_immediate_op: begin
          s_next.rcount = 16'(e_imm[ex_pkg::REPEAT_SHORT_W-1:0]);
          s_next.armed  = 1'b1;
        end
        default: ;
      endcase
      if (in_rep) begin
        s_next.rcount = s_reg.rcount - 16'h0001;
        if (s_reg.rcount == 16'h0001) s_next.fsm = S_IDLE;
      end else if (s_reg.armed && (e_op != ex_pkg::repeat_next_op) &&
                   (e_op != ex_pkg::repeat_short_immediate_op)) begin
        s_next.armed = 1'b0;
        if ((s_reg.rcount != '0) && !one_shot(e_op)) begin
          s_next.fsm     = S_REP;
          s_next.h_op    = e_op;
          s_next.h_src   = e_src;
          s_next.h_imm   = e_imm;
          s_next.h_shift = e_shift;
          s_next.h_cond  = e_cond;
        end
      end
    end
    if ((s_reg.fsm == S_IO) && ready_i) begin
      s_next.fsm      = S_IDLE;
      s_next.io_n     = 1'b1;
      s_next.strobe_n = 1'b1;
      s_next.rw       = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg          <= '0;
      s_reg.io_n     <= 1'b1;
      s_reg.strobe_n <= 1'b1;
      s_reg.rw       <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign instr_ready_o              = (s_reg.fsm == S_IDLE);
  assign mem_wr_o                   = s_reg.mem_wr;
  assign mem_wdata_o                = s_reg.mem_wdata;
  assign pc_load_o                  = s_reg.pc_load;
  assign pc_value_o                 = s_reg.pc_value;
  assign io_space_select_n_o        = s_reg.io_n;
  assign external_access_strobe_n_o = s_reg.strobe_n;
  assign io_read_write_o            = s_reg.rw;
  assign io_addr_o                  = s_reg.io_addr;
  assign io_data_o                  = s_reg.io_data;
  assign reg_rdata_o                = s_reg.rdata;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence io_start;
    go && (e_op == ex_pkg::port_out_op);
  endsequence
  sequence io_held;
    !io_space_select_n_o && !external_access_strobe_n_o && !io_read_write_o;
  endsequence

  AST_MUL_MEM: assert property (go && (e_op == ex_pkg::multiply_op) && (e_src == ex_pkg::SRC_MEM) |=>
    s_reg.prod == smul($past(s_reg.mcand), $past(mem_data_i))) else $error("multiply product wrong");
  AST_MUL_SHORT: assert property (go && (e_op == ex_pkg::multiply_short_immediate_op) |=>
    s_reg.prod == smul($past(s_reg.mcand), $past(short_opnd))) else $error("short multiply wrong");
  AST_NEGATE: assert property (go && (e_op == ex_pkg::negate_op) && !s_reg.sat_mode |=>
    s_reg.acc == 32'(-$past(s_reg.acc))) else $error("negate wrong");
  AST_NMI: assert property (go && (e_op == ex_pkg::soft_nmi_op) |=>
    pc_load_o && (pc_value_o == ex_pkg::NMI_VECTOR) && (s_reg.stk[0] == $past(next_pc_i)))
    else $error("nmi vector wrong");
  AST_OUT_START: assert property (io_start |=> io_held) else $error("port write not started");
  AST_OUT_END: assert property ((io_held and ready_i) |=>
    io_space_select_n_o && external_access_strobe_n_o) else $error("port write not ended");
  AST_POP_ACC: assert property (go && (e_op == ex_pkg::pop_to_accumulator_op) |=>
    (s_reg.acc == {16'h0000, $past(s_reg.stk[0])}) && (s_reg.stk[0] == $past(s_reg.stk[1])))
    else $error("pop to accumulator wrong");
  AST_PUSH_MEM: assert property (go && (e_op == ex_pkg::push_from_memory_op) |=>
    (s_reg.stk[0] == $past(mem_data_i)) && (s_reg.stk[1] == $past(s_reg.stk[0])))
    else $error("push from memory wrong");
  AST_CARRY_CLR: assert property (go && (e_op == ex_pkg::carry_clear_op) |=> !s_reg.carry)
    else $error("carry not cleared");
  AST_RETURN: assert property (go && (e_op == ex_pkg::subroutine_return_op) |=>
    pc_load_o && (pc_value_o == $past(s_reg.stk[0]))) else $error("return target wrong");
  AST_ROT_LEFT: assert property (go && (e_op == ex_pkg::rotate_left_op) |=>
    (s_reg.acc == {$past(s_reg.acc[30:0]), $past(s_reg.carry)}) && (s_reg.carry == $past(s_reg.acc[31])))
    else $error("rotate left wrong");
  AST_SAT_CLR: assert property (go && (e_op == ex_pkg::saturation_mode_clear_op) |=> !s_reg.sat_mode)
    else $error("saturation not cleared");
  AST_REP_LOAD: assert property (go && (e_op == ex_pkg::repeat_short_immediate_op) |=>
    s_reg.armed && (s_reg.rcount == {8'h00, $past(e_imm[7:0])})) else $error("repeat count wrong");
  AST_REP_END: assert property (in_rep && (s_reg.rcount == 16'h0001) |=>
    instr_ready_o && (s_reg.rcount == 16'h0000)) else $error("repeat did not end");

endmodule // dsp_exec

// ---- logic/ex_pkg.sv ----
// Shared constants, opcodes and register map of the DSP execute unit.
package ex_pkg;

  // ****************************************
  // Widths and fixed values
  // ****************************************
  localparam int          STACK_DEPTH    = 8;
  localparam int          SHORT_IMM_W    = 13;
  localparam int          REPEAT_SHORT_W = 8;
  localparam int          PSHIFT_L4_AMT  = 4;
  localparam int          PSHIFT_R6_AMT  = 6;
  localparam logic [15:0] NMI_VECTOR     = 16'h0024;
  localparam logic [31:0] SAT_MAX        = 32'h7FFFFFFF;
  localparam logic [31:0] SAT_MIN        = 32'h80000000;

  // ****************************************
  // Product shift encodings
  // ****************************************
  localparam logic [1:0] PSHIFT_NONE   = 2'h0;
  localparam logic [1:0] PSHIFT_LEFT1  = 2'h1;
  localparam logic [1:0] PSHIFT_LEFT4  = 2'h2;
  localparam logic [1:0] PSHIFT_RIGHT6 = 2'h3;

  // ****************************************
  // Return condition bits
  // ****************************************
  localparam int COND_W  = 6;
  localparam int COND_EQ = 0;
  localparam int COND_NE = 1;
  localparam int COND_LT = 2;
  localparam int COND_GT = 3;
  localparam int COND_C  = 4;
  localparam int COND_NC = 5;

  // ****************************************
  // Register map and status layout
  // ****************************************
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_ACC    = 3'h1;
  localparam logic [2:0] REG_PROD   = 3'h2;
  localparam logic [2:0] REG_MCAND  = 3'h3;
  localparam logic [2:0] REG_COUNT  = 3'h4;
  localparam logic [2:0] REG_TOP    = 3'h5;
  localparam int         ST_PSHIFT  = 0;
  localparam int         ST_CARRY   = 2;
  localparam int         ST_SAT     = 3;

  typedef enum logic [4:0] {
    nop_op, multiply_op, multiply_accumulate_op, multiply_short_immediate_op,
    multiply_subtract_op, multiply_unsigned_op, negate_op, soft_nmi_op,
    normalize_op, or_op, port_out_op, product_to_accumulator_op,
    pop_to_accumulator_op, pop_to_memory_op, push_from_memory_op,
    push_accumulator_op, carry_clear_op, subroutine_return_op,
    conditional_return_op, rotate_left_op, rotate_right_op,
    saturation_mode_clear_op, repeat_next_op, repeat_short_immediate_op
  } op_t;

  typedef enum logic [1:0] {SRC_MEM, SRC_SHORT, SRC_LONG} src_t;

endpackage

// ---- testbench/dsp_core_instr_mpy_to_rpt_tb.sv ----
// Self-checking bench of the execute unit.
module dsp_core_instr_mpy_to_rpt_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, vld = 0, rdy, rw_wr = 0, rw_rd = 0, mwr, pcl, sel_n, stb_n, iorw, prdy;
  ex_pkg::op_t op = ex_pkg::nop_op;
  ex_pkg::src_t src = ex_pkg::SRC_MEM;
  logic [15:0] imm = 16'h0000, mem = 16'h0000, npc = 16'h0ABC, mwd, pcv, ioa, iod, ga, gd;
  logic [3:0] sh = 4'h0;
  logic [5:0] cnd = 6'h00;
  logic [2:0] ra = 3'h0;
  logic [31:0] rwd = 32'h0, rdat;
  int err_total = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  dsp_exec dut (.clk_i(clk), .reset_n_i(rst_n), .instr_valid_i(vld), .instr_op_i(op), .instr_src_i(src),
    .instr_imm_i(imm), .instr_shift_i(sh), .instr_cond_i(cnd), .next_pc_i(npc), .instr_ready_o(rdy),
    .mem_data_i(mem), .mem_wr_o(mwr), .mem_wdata_o(mwd), .pc_load_o(pcl), .pc_value_o(pcv),
    .ready_i(prdy), .io_space_select_n_o(sel_n), .external_access_strobe_n_o(stb_n),
    .io_read_write_o(iorw), .io_addr_o(ioa), .io_data_o(iod), .reg_addr_i(ra), .reg_wdata_i(rwd),
    .reg_wr_i(rw_wr), .reg_rd_i(rw_rd), .reg_rdata_o(rdat));
  io_port_model port (.clk_i(clk), .reset_n_i(rst_n), .select_n_i(sel_n), .strobe_n_i(stb_n),
    .addr_i(ioa), .data_i(iod), .ready_o(prdy), .got_addr_o(ga), .got_data_o(gd));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk) {rw_wr, ra, rwd} <= {1'b1, a, d};
    @(posedge clk) rw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    @(posedge clk) {rw_rd, ra} <= {1'b1, a};
    @(posedge clk) rw_rd <= 1'b0;
    @(negedge clk) chk(rdat, e);
  endtask
  task automatic iss(input ex_pkg::op_t o, input logic [15:0] m = 16'h0000, input logic [15:0] i = 16'h0000,
                     input ex_pkg::src_t s = ex_pkg::SRC_MEM, input logic [3:0] h = 4'h0,
                     input logic [5:0] c = 6'h00);
    @(posedge clk) begin
      vld <= 1'b1;
      op  <= o;
      mem <= m;
      imm <= i;
      src <= s;
      sh  <= h;
      cnd <= c;
    end
    forever begin
      @(negedge clk);
      if (rdy === 1'b1) break;
    end
    @(posedge clk) vld <= 1'b0;
  endtask
  task automatic wt(input int e);
    int n;
    n = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    chk(n, e);
  endtask
  task automatic pc_chk(input logic l, input logic [15:0] v);
    @(negedge clk) chk({31'h0, pcl}, {31'h0, l});
    if (l) chk({16'h0, pcv}, {16'h0, v});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_mult;
    logic [31:0] pe [4] = '{32'hFFFFFFFD, 32'hFFFFFFFA, 32'hFFFFFFD0, 32'hFFFFFFFF};
    wr(ex_pkg::REG_MCAND, 32'h3);
    iss(ex_pkg::multiply_op, 16'hFFFE); rd(ex_pkg::REG_PROD, 32'hFFFFFFFA);
    iss(ex_pkg::multiply_op, 0, 16'h0010, ex_pkg::SRC_LONG); rd(ex_pkg::REG_PROD, 32'h30);
    iss(ex_pkg::multiply_unsigned_op, 16'hFFFE); rd(ex_pkg::REG_PROD, 32'h2FFFA);
    iss(ex_pkg::multiply_op, 0, 16'hF002, ex_pkg::SRC_SHORT); rd(ex_pkg::REG_PROD, 32'hFFFFD006);
    iss(ex_pkg::multiply_short_immediate_op, 0, 16'h1FFF, ex_pkg::SRC_SHORT);
    rd(ex_pkg::REG_PROD, 32'hFFFFFFFD);
    for (int k = 0; k < 4; k++) begin
      wr(ex_pkg::REG_STATUS, k);
      iss(ex_pkg::product_to_accumulator_op); rd(ex_pkg::REG_ACC, pe[k]);
    end
    wr(ex_pkg::REG_STATUS, 32'h0);
    iss(ex_pkg::multiply_accumulate_op, 16'h0002); rd(ex_pkg::REG_ACC, 32'hFFFFFFFC);
    iss(ex_pkg::multiply_subtract_op, 16'h0001); rd(ex_pkg::REG_ACC, 32'hFFFFFFF6);
    rd(ex_pkg::REG_PROD, 32'h3);
    iss(ex_pkg::negate_op); rd(ex_pkg::REG_ACC, 32'hA);
  endtask
  task automatic t_status;
    wr(ex_pkg::REG_STATUS, 32'h4);
    iss(ex_pkg::rotate_left_op); rd(ex_pkg::REG_ACC, 32'h15); rd(ex_pkg::REG_STATUS, 32'h0);
    iss(ex_pkg::rotate_right_op); rd(ex_pkg::REG_ACC, 32'hA); rd(ex_pkg::REG_STATUS, 32'h4);
    iss(ex_pkg::carry_clear_op); rd(ex_pkg::REG_STATUS, 32'h0);
    wr(ex_pkg::REG_STATUS, 32'h8);
    iss(ex_pkg::saturation_mode_clear_op); rd(ex_pkg::REG_STATUS, 32'h0);
    iss(ex_pkg::or_op, 0, 16'h00F0, ex_pkg::SRC_LONG, 4'hC); rd(ex_pkg::REG_ACC, 32'h000F000A);
    iss(ex_pkg::or_op, 16'h0101); rd(ex_pkg::REG_ACC, 32'h000F010B);
  endtask
  task automatic t_stack;
    iss(ex_pkg::push_accumulator_op); rd(ex_pkg::REG_TOP, 32'h010B);
    iss(ex_pkg::push_from_memory_op, 16'h1234); rd(ex_pkg::REG_TOP, 32'h1234);
    iss(ex_pkg::pop_to_memory_op);
    @(negedge clk) chk({mwr, mwd}, {1'b1, 16'h1234});
    @(negedge clk) chk({31'h0, mwr}, 32'h0);
    rd(ex_pkg::REG_TOP, 32'h010B);
    iss(ex_pkg::pop_to_accumulator_op); rd(ex_pkg::REG_ACC, 32'h010B);
    iss(ex_pkg::push_from_memory_op, 16'h0456);
    iss(ex_pkg::subroutine_return_op); pc_chk(1, 16'h0456); pc_chk(0, 0);
    iss(ex_pkg::push_from_memory_op, 16'h0777);
    iss(ex_pkg::conditional_return_op, 0, 0, ex_pkg::SRC_MEM, 0, 6'h01); pc_chk(0, 0);
    iss(ex_pkg::conditional_return_op, 0, 0, ex_pkg::SRC_MEM, 0, 6'h22); pc_chk(1, 16'h0777);
    iss(ex_pkg::soft_nmi_op); pc_chk(1, ex_pkg::NMI_VECTOR); rd(ex_pkg::REG_TOP, 32'h0ABC);
  endtask
  task automatic t_port_rpt;
    iss(ex_pkg::port_out_op, 16'hBEEF, 16'h0005);
    @(negedge clk) chk({sel_n, stb_n, iorw, ioa, iod}, {3'b000, 16'h0005, 16'hBEEF});
    wt(2); chk({sel_n, iorw, ga, gd}, {2'b11, 16'h0005, 16'hBEEF});
    iss(ex_pkg::repeat_short_immediate_op, 0, 16'h0003, ex_pkg::SRC_SHORT);
    iss(ex_pkg::rotate_left_op); wt(3); rd(ex_pkg::REG_ACC, 32'h10B0);
    rd(ex_pkg::REG_COUNT, 32'h0);
    iss(ex_pkg::repeat_next_op, 16'h0301);
    iss(ex_pkg::normalize_op); wt(1); rd(ex_pkg::REG_ACC, 32'h42C0);
    wr(ex_pkg::REG_ACC, 32'h5); rd(ex_pkg::REG_ACC, 32'h42C0);
    rd(3'h6, 32'h0);
    iss(ex_pkg::repeat_next_op, 0, 16'h0102, ex_pkg::SRC_LONG); rd(ex_pkg::REG_COUNT, 32'h102);
  endtask
  // ****************************************
  // Run control
  // ****************************************
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_mult();
    t_status();
    t_stack();
    t_port_rpt();
    wrap_up();
  end
endmodule // dsp_core_instr_mpy_to_rpt_tb

// ---- testbench/io_port_model.sv ----
// Model of the external I/O port that answers port writes after a short wait.
module io_port_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Port access
  input  wire logic        select_n_i,
  input  wire logic        strobe_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] data_i,
  output logic             ready_o,
  output logic [15:0]      got_addr_o,
  output logic [15:0]      got_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_reg;
  logic       act;
  assign act = !select_n_i && !strobe_n_i;
  // ****************************************
  // Slow ready: two wait cycles, then one ready cycle, then data taken.
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_reg   <= 2'h0;
      ready_o    <= 1'b0;
      got_addr_o <= 16'h0000;
      got_data_o <= 16'h0000;
    end else begin
      wait_reg <= act ? wait_reg + 2'h1 : 2'h0;
      ready_o  <= act && !ready_o && wait_reg == 2'h1;
      if (act && ready_o) begin
        got_addr_o <= addr_i;
        got_data_o <= data_i;
      end
    end
  end
endmodule // io_port_model
